/* shared/speed_monitor_pkg.sv */
// Constants shared by the safe input evaluation and speed measurement logic
package speed_monitor_pkg;
    // ------------------------------------------------------------
    // Clock and time base
    // ------------------------------------------------------------
    localparam int clk_hz             = 200_000_000;
    localparam int clk_period_ns      = 5;
    localparam int self_test_max_us   = 350;
    localparam int self_test_cycles   =
        self_test_max_us * 1000 / clk_period_ns;
    localparam int test_half_us       = 100;
    localparam int test_half_cycles   =
        (test_half_us * 1000 + clk_period_ns - 1) / clk_period_ns;
    localparam int timer_width        = 17;
    localparam int test_cnt_width     = 16;

    // ------------------------------------------------------------
    // Frequency measurement
    // ------------------------------------------------------------
    localparam int freq_width         = 16;
    localparam int period_width       = 27;
    localparam int freq_units_per_hz  = 10;
    localparam int min_freq_hz        = 2;
    localparam int max_freq_hz        = 500;
    localparam logic [31:0] freq_numerator =
        32'(64'(clk_hz) * 64'(freq_units_per_hz));
    localparam logic [period_width-1:0] max_period =
        period_width'(clk_hz / min_freq_hz);
    localparam logic [period_width-1:0] sat_period =
        period_width'(freq_numerator / 32'h0001_0000 + 32'h1);
    localparam logic [freq_width-1:0] overrange_limit =
        freq_width'(max_freq_hz * freq_units_per_hz);
    localparam logic [freq_width-1:0] freq_saturated = 16'hffff;
    localparam logic [3:0] div_last_step = 4'hf;

    // ------------------------------------------------------------
    // Addressing and restore parameters
    // ------------------------------------------------------------
    localparam int addr_width = 12;
    localparam logic [addr_width-1:0] address_min = 12'h001;
    localparam logic [15:0] store_code_reset  = 16'h0000;
    localparam logic [15:0] project_crc_reset = 16'h0000;

    // ------------------------------------------------------------
    // Pair logic modes
    // ------------------------------------------------------------
    localparam logic [1:0] pair_single                  = 2'h0;
    localparam logic [1:0] pair_staggered_test_optical  = 2'h1;
    localparam logic [1:0] pair_any_pulse_optical       = 2'h2;
    localparam logic [1:0] pair_cross_circuit_mat       = 2'h3;
endpackage

/* shared/channel_meter_if.sv */
// Signals between the evaluation core and one channel's period meter
`timescale 1ns/10ps
interface channel_meter_if;
    logic        level;
    logic [15:0] freq;
    logic        update;
    modport meter (input level, output freq, output update);
    modport owner (output level, input freq, input update);
endinterface

/* rtl/channel_period_meter.sv */
// Falling-edge period counter and divider giving frequency in 0.1 Hz
`timescale 1ns/10ps
module channel_period_meter (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       enable,
    channel_meter_if.meter  ch
);
    typedef enum logic [1:0] {
        st_idle = 2'b01,
        st_div  = 2'b10
    } div_state_type;

    typedef struct packed {
        div_state_type                                  fsm;
        logic                                           prev_level;
        logic                                           armed;
        logic [speed_monitor_pkg::period_width-1:0]     period;
        logic [31:0]                                    rem;
        logic [42:0]                                    dsh;
        logic [15:0]                                    quot;
        logic [3:0]                                     step;
        logic [15:0]                                    freq;
        logic                                           update;
    } meter_state_type;

    meter_state_type s;
    meter_state_type next_s;

    always_comb begin
        next_s        = s;
        next_s.update = 1'b0;
        next_s.prev_level = ch.level;
        // Period saturates one past the 2 Hz limit
        if (s.period <= speed_monitor_pkg::max_period) begin
            next_s.period = s.period + 27'h1;
        end
        if (s.period == speed_monitor_pkg::max_period) begin
            next_s.freq   = 16'h0000;
            next_s.update = 1'b1;
        end
        unique case (s.fsm)
            st_idle: begin
            end
            st_div: begin
                if ({11'h000, s.rem} >= s.dsh) begin
                    next_s.rem  = s.rem - s.dsh[31:0];
                    next_s.quot = {s.quot[14:0], 1'b1};
                end else begin
                    next_s.quot = {s.quot[14:0], 1'b0};
                end
                next_s.dsh  = s.dsh >> 1;
                next_s.step = s.step - 4'h1;
                if (s.step == 4'h0) begin
                    next_s.fsm    = st_idle;
                    next_s.freq   = next_s.quot;
                    next_s.update = 1'b1;
                end
            end
        endcase
        if (s.prev_level && !ch.level) begin
            next_s.armed  = 1'b1;
            next_s.period = 27'h1;
            if (s.armed && s.period <= speed_monitor_pkg::max_period) begin
                if (s.period < speed_monitor_pkg::sat_period) begin
                    next_s.freq   = speed_monitor_pkg::freq_saturated;
                    next_s.update = 1'b1;
                    next_s.fsm    = st_idle;
                end else begin
                    next_s.fsm  = st_div;
                    next_s.rem  = speed_monitor_pkg::freq_numerator;
                    next_s.dsh  = {1'b0, s.period, 15'h0000};
                    next_s.quot = 16'h0000;
                    next_s.step = speed_monitor_pkg::div_last_step;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s        <= '0;
            s.fsm    <= st_idle;
            s.period <= speed_monitor_pkg::max_period + 27'h1;
        end else if (enable) begin
            s <= next_s;
        end
    end

    assign ch.freq   = s.freq;
    assign ch.update = s.update;

    a_timeout_zero: assert property (@(posedge clk) disable iff (reset)
        enable && s.period == speed_monitor_pkg::max_period
        && !(s.prev_level && !ch.level) |=> ch.freq == 16'h0000)
        else $error("slow input not reported as zero");

    a_edge_result: assert property (@(posedge clk) disable iff (reset)
        enable && s.prev_level && !ch.level && s.armed
        && s.period <= speed_monitor_pkg::max_period
        && s.period >= speed_monitor_pkg::sat_period
        ##1 (enable && !(s.prev_level && !ch.level)) [*8]
        ##1 (enable && !(s.prev_level && !ch.level)) [*8]
        ##1 enable
        |-> ##[0:2] ch.update)
        else $error("no frequency result after falling edge");
endmodule

/* rtl/safe_input_speed_monitor.sv */
// Eight-channel safe input evaluation with test pulses and speed monitor
`timescale 1ns/10ps
module safe_input_speed_monitor #(
    parameter int SELF_TEST_CYCLES = speed_monitor_pkg::self_test_cycles,
    parameter int TEST_HALF_CYCLES = speed_monitor_pkg::test_half_cycles
) (
    input  wire logic             CLK_SYS,
    input  wire logic             RESET,
    input  wire logic             CLK_EN,
    input  wire logic [7:0]       INPUT_PIN,
    input  wire logic [7:0]       TEST_ENABLE,
    input  wire logic [7:0]       SPEED_MODE,
    input  wire logic [3:0][1:0]  PAIR_MODE,
    input  wire logic [7:0][15:0] VELOCITY_LIMIT,
    input  wire logic             ERROR_ACKNOWLEDGE,
    input  wire logic [11:0]      ADDRESS_SWITCH,
    input  wire logic             ADDRESS_FROM_PARAM,
    input  wire logic [11:0]      ADDRESS_PARAM,
    input  wire logic             RESTORE_LOAD,
    input  wire logic [15:0]      STORE_CODE_IN,
    input  wire logic [15:0]      PROJECT_CRC_IN,
    output logic [7:0]            TEST_OUT,
    output logic [7:0]            SAFE_INPUT,
    output logic [7:0][15:0]      FREQUENCY,
    output logic [7:0]            OVERRANGE,
    output logic [7:0]            TEST_FAULT,
    output logic [11:0]           SAFETY_LINK_ADDRESS,
    output logic                  ADDRESS_VALID,
    output logic [15:0]           STORE_CODE,
    output logic [15:0]           PROJECT_CRC
);
    localparam int tw = speed_monitor_pkg::timer_width;
    localparam int cw = speed_monitor_pkg::test_cnt_width;

    if (SELF_TEST_CYCLES < 1 || SELF_TEST_CYCLES >= (1 << tw)) begin : g_bad1
        $error("SELF_TEST_CYCLES out of range");
    end
    if (TEST_HALF_CYCLES < 4 || TEST_HALF_CYCLES >= (1 << cw)) begin : g_bad2
        $error("TEST_HALF_CYCLES out of range");
    end

    localparam logic [tw-1:0] grace   = tw'(SELF_TEST_CYCLES);
    localparam logic [cw-1:0] half_lc = cw'(TEST_HALF_CYCLES - 1);

    typedef struct packed {
        logic [7:0]          sync1;
        logic [7:0]          sync2;
        logic [7:0]          test_out;
        logic [7:0]          test_bad;
        logic [7:0]          test_fault;
        logic [7:0]          safe;
        logic [7:0]          overrange;
        logic                pattern;
        logic [cw-1:0]       test_cnt;
        logic [3:0][tw-1:0]  pair_timer;
        logic                ack_prev;
        logic [11:0]         address;
        logic                address_valid;
        logic [15:0]         store_code;
        logic [15:0]         project_crc;
    } core_state_type;

    core_state_type s;
    core_state_type next_s;

    // ------------------------------------------------------------
    // Per-channel period meters
    // ------------------------------------------------------------
    channel_meter_if ch [8] ();

    for (genvar i = 0; i < 8; i++) begin : g_chan
        assign ch[i].level = s.sync2[i];
        assign FREQUENCY[i] = ch[i].freq;
        channel_period_meter u_meter (
            .clk    (CLK_SYS),
            .reset  (RESET),
            .enable (CLK_EN),
            .ch     (ch[i])
        );
    end

    logic [7:0][15:0] freq;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            freq[i] = FREQUENCY[i];
        end
    end

    // ------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------
    // Equal counts as too fast: a safe stop beats a missed overspeed
    function automatic logic below_limit(input logic [15:0] f,
                                         input logic [15:0] lim);
        below_limit = f < lim;
    endfunction

    // Optical pair: a lone low is a self-test pulse for a short while;
    // both low only gets that grace in the any-pulse mode
    function automatic logic optical_ok(input logic [1:0]    mode,
                                        input logic [tw-1:0] timer,
                                        input logic          la,
                                        input logic          lb);
        logic in_grace;
        in_grace   = timer < grace;
        optical_ok = (la && lb)
            || (in_grace && (la || lb))
            || (in_grace
                && mode == speed_monitor_pkg::pair_any_pulse_optical);
    endfunction

    logic        ack_rise;
    logic [11:0] addr_pick;
    logic        end_half;

    always_comb begin
        logic [1:0] mode;
        logic       la;
        logic       lb;
        logic       pv;
        mode      = 2'h0;
        la        = 1'b0;
        lb        = 1'b0;
        pv        = 1'b0;
        next_s    = s;
        ack_rise  = ERROR_ACKNOWLEDGE && !s.ack_prev;
        end_half  = s.test_cnt == half_lc;
        addr_pick = ADDRESS_FROM_PARAM ? ADDRESS_PARAM : ADDRESS_SWITCH;

        next_s.sync1    = INPUT_PIN;
        next_s.sync2    = s.sync1;
        next_s.ack_prev = ERROR_ACKNOWLEDGE;

        // Link address: a zero selection is refused, last good kept
        next_s.address_valid = addr_pick >= speed_monitor_pkg::address_min;
        if (addr_pick >= speed_monitor_pkg::address_min) begin
            next_s.address = addr_pick;
        end

        if (RESTORE_LOAD) begin
            next_s.store_code  = STORE_CODE_IN;
            next_s.project_crc = PROJECT_CRC_IN;
        end

        // --------------------------------------------------------
        // Test pulse generation and read-back
        // --------------------------------------------------------
        next_s.test_cnt = end_half ? '0 : s.test_cnt + cw'(1);
        if (end_half) begin
            next_s.pattern = !s.pattern;
        end
        for (int i = 0; i < 8; i++) begin
            // Idle test outputs sit high so plain contacts read normally
            next_s.test_out[i] = TEST_ENABLE[i] ? next_s.pattern
                                                : 1'b1;
            if (end_half) begin
                next_s.test_bad[i] = TEST_ENABLE[i]
                    && (s.sync2[i] != s.test_out[i]);
            end
            if (ack_rise) begin
                next_s.test_fault[i] = 1'b0;
            end
            if (next_s.test_bad[i]
                && PAIR_MODE[i/2] != speed_monitor_pkg::pair_cross_circuit_mat
                && !SPEED_MODE[i]) begin
                next_s.test_fault[i] = 1'b1;
            end
        end

        // --------------------------------------------------------
        // Pair and channel evaluation
        // --------------------------------------------------------
        for (int p = 0; p < 4; p++) begin
            mode = PAIR_MODE[p];
            la   = s.sync2[2*p];
            lb   = s.sync2[2*p+1];
            if ((la && lb) || mode == speed_monitor_pkg::pair_single
                || mode == speed_monitor_pkg::pair_cross_circuit_mat) begin
                next_s.pair_timer[p] = '0;
            end else if (s.pair_timer[p] < grace) begin
                next_s.pair_timer[p] = s.pair_timer[p] + tw'(1);
            end
            pv = 1'b0;
            unique case (mode)
                speed_monitor_pkg::pair_single: begin
                end
                speed_monitor_pkg::pair_staggered_test_optical,
                speed_monitor_pkg::pair_any_pulse_optical: begin
                    pv = optical_ok(mode, s.pair_timer[p], la, lb);
                end
                speed_monitor_pkg::pair_cross_circuit_mat: begin
                    // A cross short shows as a read-back mismatch
                    pv = la && lb && !s.test_bad[2*p]
                        && !s.test_bad[2*p+1];
                end
            endcase
            for (int k = 0; k < 2; k++) begin
                if (SPEED_MODE[2*p+k]) begin
                    next_s.safe[2*p+k] =
                        below_limit(freq[2*p+k],
                                    VELOCITY_LIMIT[2*p+k]);
                end else if (mode == speed_monitor_pkg::pair_single) begin
                    next_s.safe[2*p+k] = s.sync2[2*p+k]
                        && !s.test_fault[2*p+k];
                end else begin
                    next_s.safe[2*p+k] = pv;
                end
            end
        end

        // Over-range: a new excess wins over a same-cycle acknowledge
        for (int i = 0; i < 8; i++) begin
            if (ack_rise) begin
                next_s.overrange[i] = 1'b0;
            end
            if (SPEED_MODE[i] && freq[i] > speed_monitor_pkg::overrange_limit)
            begin
                next_s.overrange[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            s             <= '0;
            s.test_out    <= 8'hff;
            s.safe        <= 8'h00;
            s.store_code  <= speed_monitor_pkg::store_code_reset;
            s.project_crc <= speed_monitor_pkg::project_crc_reset;
        end else if (CLK_EN) begin
            s <= next_s;
        end
    end

    assign TEST_OUT            = s.test_out;
    assign SAFE_INPUT          = s.safe;
    assign OVERRANGE           = s.overrange;
    assign TEST_FAULT          = s.test_fault;
    assign SAFETY_LINK_ADDRESS = s.address;
    assign ADDRESS_VALID       = s.address_valid;
    assign STORE_CODE          = s.store_code;
    assign PROJECT_CRC         = s.project_crc;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_address_nonzero: assert property (@(posedge CLK_SYS)
        disable iff (RESET) ADDRESS_VALID |-> SAFETY_LINK_ADDRESS != 12'h000)
        else $error("valid link address is zero");

    a_test_idle_high: assert property (@(posedge CLK_SYS)
        disable iff (RESET) CLK_EN && !TEST_ENABLE[0] |=> TEST_OUT[0])
        else $error("test output low while test disabled");

    a_restore_zero: assert property (@(posedge CLK_SYS)
        RESET |=> STORE_CODE == 16'h0000 && PROJECT_CRC == 16'h0000)
        else $error("restore parameters not zero after reset");

    a_limit_compare: assert property (@(posedge CLK_SYS)
        disable iff (RESET) CLK_EN && SPEED_MODE[0]
        |=> SAFE_INPUT[0] == ($past(FREQUENCY[0]) < $past(VELOCITY_LIMIT[0])))
        else $error("speed channel result wrong");

    a_staggered_both: assert property (@(posedge CLK_SYS)
        disable iff (RESET) CLK_EN && !SPEED_MODE[6]
        && PAIR_MODE[3] == speed_monitor_pkg::pair_staggered_test_optical
        && !s.sync2[6] && !s.sync2[7] |=> !SAFE_INPUT[6])
        else $error("staggered pair passed simultaneous low");

    a_overrange_set: assert property (@(posedge CLK_SYS)
        disable iff (RESET) CLK_EN && SPEED_MODE[0]
        && FREQUENCY[0] > speed_monitor_pkg::overrange_limit
        ##1 !(ERROR_ACKNOWLEDGE && !s.ack_prev)
        |-> OVERRANGE[0] ##1 OVERRANGE[0])
        else $error("over-range not raised");

    a_ack_clears: assert property (@(posedge CLK_SYS)
        disable iff (RESET) CLK_EN && ERROR_ACKNOWLEDGE && !s.ack_prev
        && !(SPEED_MODE[0]
             && FREQUENCY[0] > speed_monitor_pkg::overrange_limit)
        |=> !OVERRANGE[0])
        else $error("acknowledge edge did not clear diagnostic");
endmodule

/* verification/pulse_encoder_model.sv */
// Pulse encoder model: square wave with a programmable period
`timescale 1ns/10ps
module pulse_encoder_model (
    input  wire logic        clk,
    input  wire logic        run,
    input  wire logic [31:0] period,
    output logic             line
);
    logic [31:0] count;

    initial begin
        count = 32'h0;
        line  = 1'b1;
    end

    // Low half first, so starting from idle gives the arming edge at once
    always @(negedge clk) begin
        if (!run) begin
            count <= 32'h0;
            line  <= 1'b1;
        end else begin
            count <= (count + 32'h1 >= period) ? 32'h0 : count + 32'h1;
            line  <= (count < (period >> 1)) ? 1'b0 : 1'b1;
        end
    end
endmodule

/* verification/test_safe_input_speed_monitor.sv */
// Self-checking bench for the eight-channel safe input evaluator
`timescale 1ns/10ps
module test_safe_input_speed_monitor;
    // ------------------------------------------------------------
    // Stimulus, design and partner
    // ------------------------------------------------------------
    logic             clk = 1'b0;
    logic             reset = 1'b1;
    logic [7:0]       test_en = 8'h00;
    logic [7:0]       speed = 8'h00;
    logic [3:0][1:0]  pair = 8'h00;
    logic [7:0][15:0] limit = 128'h0;
    logic             ack = 1'b0;
    logic [11:0]      sw = 12'h000;
    logic             from_param = 1'b0;
    logic [11:0]      param = 12'h000;
    logic             load = 1'b0;
    logic [15:0]      code_in = 16'h0000;
    logic [15:0]      crc_in = 16'h0000;
    logic             lvl1 = 1'b0;
    logic [1:0]       opt = 2'h3;
    logic             run = 1'b0;
    logic             en = 1'b1;
    logic [31:0]      per = 32'h0000_7d00;
    logic             enc;
    logic [7:0]       pin, test_out, safe, ovr, fault;
    logic [7:0][15:0] freq;
    logic [11:0]      addr;
    logic             valid;
    logic [15:0]      code, crc;
    logic [31:0]      seed = 32'h4679ac27;
    logic [63:0]      exp_q[$], msk_q[$];
    int               sel_q[$];
    event             look;
    int               n_mismatch = 0;
    int               total_checks = 0;

    always #2.5 clk = ~clk;

    // Ch3 stuck high, ch5 stuck low: both must fail their test pulse
    assign pin = {opt, 1'b0, test_out[4], 1'b1, test_out[2], lvl1, enc};

    safe_input_speed_monitor #(
        .SELF_TEST_CYCLES (50),
        .TEST_HALF_CYCLES (16)
    ) safe_input_speed_monitor_i (
        .CLK_SYS (clk), .RESET (reset), .CLK_EN (en),
        .INPUT_PIN (pin), .TEST_ENABLE (test_en), .SPEED_MODE (speed),
        .PAIR_MODE (pair), .VELOCITY_LIMIT (limit),
        .ERROR_ACKNOWLEDGE (ack), .ADDRESS_SWITCH (sw),
        .ADDRESS_FROM_PARAM (from_param), .ADDRESS_PARAM (param),
        .RESTORE_LOAD (load), .STORE_CODE_IN (code_in),
        .PROJECT_CRC_IN (crc_in), .TEST_OUT (test_out),
        .SAFE_INPUT (safe), .FREQUENCY (freq), .OVERRANGE (ovr),
        .TEST_FAULT (fault), .SAFETY_LINK_ADDRESS (addr),
        .ADDRESS_VALID (valid), .STORE_CODE (code), .PROJECT_CRC (crc)
    );

    pulse_encoder_model pulse_encoder_model_i (
        .clk (clk), .run (run), .period (per), .line (enc)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function logic [63:0] seen(int sel);
        case (sel)
            0: return {56'h0, safe};
            1: return {48'h0, freq[0]};
            2: return {56'h0, ovr};
            3: return {56'h0, fault};
            4: return {51'h0, valid, addr};
            5: return {32'h0, code, crc};
            default: return {56'h0, test_out};
        endcase
    endfunction

    task check(logic [63:0] got, logic [63:0] want);
        total_checks++;
        if (got !== want) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h expected=%h", $time, got, want);
        end
    endtask

    // Watcher takes the oldest note each time one is posted
    always @(look) begin
        check(seen(sel_q.pop_front()) & msk_q.pop_front(), exp_q.pop_front());
    end

    task note(int sel, logic [63:0] msk, logic [63:0] want);
        sel_q.push_back(sel);
        msk_q.push_back(msk);
        exp_q.push_back(want & msk);
        -> look;
        #0.01;
    endtask

    task cyc(int n);
        repeat (n) @(negedge clk);
    endtask

    // Both outputs low for len cycles, then back high
    task optic(logic [1:0] mode, int len, logic [1:0] want);
        pair[3] = mode;
        cyc(10);
        opt = 2'h0;
        cyc(len);
        note(0, 64'hc0, {56'h0, want, 6'h0});
        opt = 2'h3;
        cyc(60);
    endtask

    task end_sim();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [31:0] r;
        cyc(16);
        reset = 1'b0;
        cyc(2);
        note(5, 64'hffffffff, 64'h0);
        note(4, 64'h1000, 64'h0);
        note(6, 64'hff, 64'hff);
        $display("test reset done");
        for (int i = 0; i < 3; i++) begin
            r = xs();
            sw = (i == 0) ? 12'h001 : (i == 1) ? 12'hfff : {r[11:1], 1'b1};
            cyc(2);
            note(4, 64'h1fff, {51'h0, 1'b1, sw});
        end
        // Frozen core must ignore a new selection
        en = 1'b0;
        param = 12'h5a3;
        from_param = 1'b1;
        cyc(3);
        note(4, 64'h1fff, {51'h0, 1'b1, sw});
        en = 1'b1;
        cyc(2);
        note(4, 64'h1fff, 64'h15a3);
        param = 12'h000;
        cyc(2);
        note(4, 64'h1fff, 64'h05a3);
        r = xs();
        {code_in, crc_in} = r;
        load = 1'b1;
        cyc(1);
        load = 1'b0;
        code_in = ~code_in;
        cyc(2);
        note(5, 64'hffffffff, {32'h0, r});
        $display("test address and restore done");
        test_en = 8'h3c;
        pair[2] = 2'h3;
        cyc(200);
        note(3, 64'hff, 64'h08);
        note(0, 64'h38, 64'h00);
        note(6, 64'hc3, 64'hc3);
        test_en = 8'h00;
        pair[2] = 2'h0;
        // Read-back verdicts stand until the next half period ends
        cyc(20);
        ack = 1'b1;
        cyc(3);
        ack = 1'b0;
        note(3, 64'hff, 64'h00);
        $display("test pulse check done");
        optic(2'h2, 20, 2'h3);
        optic(2'h1, 10, 2'h0);
        optic(2'h2, 80, 2'h0);
        $display("test optical pairs done");
        for (int i = 1; i < 8; i++) begin
            limit[i] = xs() >> 16;
        end
        limit[0] = 16'hf424;
        speed = 8'h01;
        lvl1 = 1'b1;
        run = 1'b1;
        for (int i = 0; i < 80000 && freq[0] === 16'h0; i++) begin
            cyc(1);
        end
        if (freq[0] === 16'h0) begin
            check(64'h0, 64'hf424);
        end else begin
            cyc(3);
            note(1, 64'hffff, 64'hf424);
            note(0, 64'h03, 64'h02);
            note(2, 64'h01, 64'h01);
            limit[0] = 16'hf425;
            cyc(3);
            note(0, 64'h01, 64'h01);
            // Period too short for the divider: reading saturates
            run = 1'b0;
            per = 32'h0000_03e8;
            cyc(2);
            run = 1'b1;
            cyc(2100);
            note(1, 64'hffff, 64'hffff);
            note(0, 64'h01, 64'h00);
            speed = 8'h00;
            run = 1'b0;
            cyc(50);
            note(2, 64'h01, 64'h01);
            ack = 1'b1;
            cyc(3);
            note(2, 64'h01, 64'h00);
        end
        $display("test speed monitor done");
        end_sim();
    end
endmodule
